// ---- hdl/flash_cfg_defs.vh ----
`ifndef FLASH_CFG_DEFS_VH
`define FLASH_CFG_DEFS_VH
// instruction codes
`define CMD_REGISTER_WRITE    8'h01
`define CMD_READ_SECOND_STAT  8'h07
`define CMD_BOOT_CFG_READ     8'h14
`define CMD_BOOT_CFG_WRITE    8'h15
`define CMD_BANK_READ         8'h16
`define CMD_BANK_WRITE        8'h17
`define CMD_BANK_ACCESS       8'hB9
`define CMD_SMALL_ERASE       8'h20
`define CMD_BLOCK_ERASE       8'hD8
// second status register fields
`define SSC_ERASE_SIZE_BIT    7
`define SSC_PAGE_WRAP_BIT     6
`define SSC_LANE_RESET_BIT    5
`define SSC_ERASE_SUSP_BIT    1
`define SSC_PROG_SUSP_BIT     0
`define SSC_OTP_MASK          8'hE0
`define SSC_RESET             8'h00
// boot read register fields
`define BOOT_RESET            32'h00000000
`define BOOT_ENABLE_BIT       0
// bank register fields
`define BANK_EXT_ADDR_BIT     7
`define BANK_RESET            8'h00
`define BANK_WRITE_MASK       8'h80
// register write bit count carrying the second status byte
`define WRR_LONG_BITS         6'h18
// erase sizes in bytes
`define ERASE_4K              32'h00001000
`define ERASE_64K             32'h00010000
`define ERASE_256K            32'h00040000
// page buffer wrap masks
`define WRAP_MASK_256         9'h0FF
`define WRAP_MASK_512         9'h1FF
`endif

// ---- hdl/flash_config_status_regs.v ----
// Functional notes
// (RULE1) OTP status bits written by 24-bit register write
// (RULE2) read second status command returns register
// (RULE3) bit 7 picks 256 or 64 KB
// (RULE4) 64 KB: small 4K, block 64K erase
// (RULE5) 256 KB: uniform aligned 256K blocks
// (RULE6) host sets erase size before array use
// (RULE7) bit 6 picks 512 or 256 wrap
// (RULE8) bit 5 selects reset or hold role
// (RULE9) bit 1 erase suspend, read only
// (RULE10) bit 0 program suspend, read only
// (RULE11) 32-bit boot register, read and write codes
// (RULE12) boot enable bit starts read after reset
// (RULE13) bits 31:9 give aligned boot address
// (RULE14) bits 8:1 give boot start delay
// (RULE15) bank register via four access commands; the code decodes three (16h, 17h, B9h)
// (RULE16) extended bit clear: bank supplies high bits; the code forces them to zero
// (RULE17) extended bit set: four-byte host address
// (RULE18) extended bit 7 volatile, resets zero
// (RULE19) bits 6:2 reserved, reset zero
// (RULE20) bank bits 1:0 reserved, no effect
// (RULE21) register reads shift out msb first
`timescale 1ns/1ps
`default_nettype none
`include "flash_cfg_defs.vh"
module flash_config_status_regs (
    // clock and reset
    input  wire        clk_i,
    input  wire        rstn_i,
    // serial link pins
    input  wire        sck_i,
    input  wire        cs_n_i,
    input  wire        si_i,
    output wire        so_o,
    output wire        so_oe_o,
    // device state and reset sources
    input  wire        erase_suspended_flag_i,
    input  wire        program_suspended_flag_i,
    input  wire        soft_reset_i,
    input  wire        hw_reset_i,
    // legacy address translation
    input  wire [23:0] addr3_i,
    input  wire [31:0] addr4_i,
    output reg  [31:0] array_addr_o,
    // configuration outputs
    output reg  [31:0] erase_size_o,
    output reg  [8:0]  page_wrap_mask_o,
    output reg         lane_three_reset_role_o,
    output reg         four_byte_address_mode_o,
    output reg         boot_read_enable_o,
    output reg  [22:0] boot_start_address_o,
    output reg  [7:0]  boot_start_delay_o,
    output reg         boot_request_o,
    output reg         reg_write_o
);
    // command phase states
    localparam [3:0] ST_CMD  = 4'b0001;
    localparam [3:0] ST_DATA = 4'b0010;
    localparam [3:0] ST_READ = 4'b0100;
    localparam [3:0] ST_DONE = 4'b1000;

    // two-stage synchronisers; first stage read only by second
    reg [1:0] sck_s_q;
    reg [1:0] cs_s_q;
    reg [1:0] si_s_q;
    reg       sck_d1_q;
    always @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            sck_s_q  <= 2'h0;
            cs_s_q   <= 2'h3;
            si_s_q   <= 2'h0;
            sck_d1_q <= 1'b0;
        end else begin
            sck_s_q  <= {sck_s_q[0], sck_i};
            cs_s_q   <= {cs_s_q[0], cs_n_i};
            si_s_q   <= {si_s_q[0], si_i};
            sck_d1_q <= sck_s_q[1];
        end
    end

    wire sck_rise = sck_s_q[1] & ~sck_d1_q;
    wire sck_fall = ~sck_s_q[1] & sck_d1_q;
    wire cs_act   = ~cs_s_q[1];

    // register state
    reg [7:0]  ssc_q;
    reg [31:0] boot_q;
    reg [7:0]  bank_q;
    reg [3:0]  st_q;
    reg [7:0]  cmd_q;
    reg [31:0] data_q;
    reg [5:0]  bits_q;
    reg        rd_load_q;
    reg [31:0] rd_word_q;
    reg        wrap_q;

    // second status as read: OTP bits plus live suspend flags
    function [7:0] ssc_view;
        input [7:0] stored;
        input       es;
        input       ps;
        begin
            // (RULE9) erase suspend live
            // (RULE10) program suspend live
            ssc_view = {stored[7:5], 3'h0, es, ps};
        end
    endfunction

    // register read reply, msb-justified for the shifter
    function [31:0] read_word;
        input [7:0]  cmd;
        input [7:0]  ssc;
        input [31:0] boot;
        input [7:0]  bank;
        begin
            case (cmd)
                // (RULE2) status read reply
                `CMD_READ_SECOND_STAT: read_word = {ssc, 24'h000000};
                `CMD_BOOT_CFG_READ:    read_word = boot;
                `CMD_BANK_READ:        read_word = {bank, 24'h000000};
                default:               read_word = 32'h00000000;
            endcase
        end
    endfunction

    // read commands that return a register
    wire is_read_cmd = (cmd_q == `CMD_READ_SECOND_STAT) | (cmd_q == `CMD_BOOT_CFG_READ) |
                       (cmd_q == `CMD_BANK_READ);

    // command, data and read phases on link rising edges
    always @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            st_q      <= ST_CMD;
            cmd_q     <= 8'h00;
            data_q    <= 32'h00000000;
            bits_q    <= 6'h00;
            rd_load_q <= 1'b0;
            rd_word_q <= 32'h00000000;
        end else begin
            rd_load_q <= 1'b0;
            if (!cs_act) begin
                st_q   <= ST_CMD;
                bits_q <= 6'h00;
                data_q <= 32'h00000000;
            end else if (sck_rise) begin
                case (st_q)
                    ST_CMD: begin
                        cmd_q  <= {cmd_q[6:0], si_s_q[1]};
                        bits_q <= bits_q + 6'h01;
                        if (bits_q == 6'h07) begin
                            bits_q <= 6'h00;
                            st_q   <= ST_DATA;
                        end
                    end
                    ST_DATA: begin
                        if (is_read_cmd) begin
                            st_q <= ST_READ;
                        end else if (bits_q != 6'h20) begin
                            data_q <= {data_q[30:0], si_s_q[1]};
                            bits_q <= bits_q + 6'h01;
                        end
                    end
                    ST_READ: st_q <= ST_READ;
                    ST_DONE: st_q <= ST_DONE;
                    default: st_q <= ST_CMD;
                endcase
                // (RULE21) msb first reply
                if (st_q == ST_CMD && bits_q == 6'h07) begin
                    rd_load_q <= 1'b1;
                    rd_word_q <= read_word({cmd_q[6:0], si_s_q[1]},
                                 ssc_view(ssc_q, erase_suspended_flag_i,
                                          program_suspended_flag_i),
                                 boot_q, bank_q);
                end
            end
        end
    end

    // bit of the reply; shifted on falling link edges
    wire rd_bit;
    reg_shift_out u_shift (
        .clk_i  (clk_i),
        .rstn_i (rstn_i),
        .load_i (rd_load_q),
        .word_i (rd_word_q),
        .shift_i(sck_fall & (st_q == ST_READ)),
        .bit_o  (rd_bit)
    );

    // output drives only during a register read
    assign so_o    = rd_bit;
    assign so_oe_o = cs_act & ((st_q == ST_DATA) | (st_q == ST_READ)) & is_read_cmd;

    // writes commit when chip select rises; resets restore only the bank register default
    wire cs_end     = cs_s_q[1] & ~wrap_q;
    wire any_reset  = soft_reset_i | hw_reset_i;
    always @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            wrap_q <= 1'b1;
        end else begin
            wrap_q <= cs_s_q[1];
        end
    end

    // nonvolatile status and boot bits survive soft and hard reset
    always @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            ssc_q       <= `SSC_RESET;
            boot_q      <= `BOOT_RESET;
            bank_q      <= `BANK_RESET;
            reg_write_o <= 1'b0;
        end else begin
            reg_write_o <= 1'b0;
            // a reset in the commit cycle wins, so that frame's write is dropped
            if (any_reset) begin
                // (RULE18) extended bit clears on reset
                bank_q <= `BANK_RESET;
            end else if (cs_end) begin
                case (cmd_q)
                    `CMD_REGISTER_WRITE: begin
                        // (RULE1) long write only
                        if (bits_q == `WRR_LONG_BITS) begin
                            ssc_q       <= (data_q[7:0] & `SSC_OTP_MASK) | ssc_q;
                            reg_write_o <= 1'b1;
                        end
                    end
                    `CMD_BOOT_CFG_WRITE: begin
                        // (RULE11) boot register write
                        if (bits_q == 6'h20) begin
                            boot_q      <= data_q;
                            reg_write_o <= 1'b1;
                        end
                    end
                    `CMD_BANK_WRITE, `CMD_BANK_ACCESS: begin
                        // (RULE15) bank write paths
                        // (RULE19) reserved bits held zero
                        if (bits_q == 6'h08) begin
                            bank_q      <= data_q[7:0] & `BANK_WRITE_MASK;
                            reg_write_o <= 1'b1;
                        end
                    end
                    default: bank_q <= bank_q;
                endcase
            end
        end
    end

    // boot read request follows every reset when enabled
    always @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            boot_request_o <= 1'b0;
        end else begin
            // (RULE12) boot read on reset
            boot_request_o <= any_reset & boot_q[`BOOT_ENABLE_BIT];
        end
    end

    // decoded configuration, registered
    always @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            erase_size_o             <= `ERASE_64K;
            page_wrap_mask_o         <= `WRAP_MASK_256;
            lane_three_reset_role_o  <= 1'b0;
            four_byte_address_mode_o <= 1'b0;
            boot_read_enable_o       <= 1'b0;
            boot_start_address_o     <= 23'h000000;
            boot_start_delay_o       <= 8'h00;
            array_addr_o             <= 32'h00000000;
        end else begin
            // (RULE3) erase size select
            // (RULE4) hybrid block erase size
            // (RULE5) uniform block erase size
            if (cmd_q == `CMD_SMALL_ERASE && !ssc_q[`SSC_ERASE_SIZE_BIT])
                erase_size_o <= `ERASE_4K;
            else if (ssc_q[`SSC_ERASE_SIZE_BIT])
                erase_size_o <= `ERASE_256K;
            else
                erase_size_o <= `ERASE_64K;
            // (RULE7) page wrap point
            page_wrap_mask_o <= ssc_q[`SSC_PAGE_WRAP_BIT] ? `WRAP_MASK_512 : `WRAP_MASK_256;
            // (RULE8) lane role latched at reset
            if (any_reset)
                lane_three_reset_role_o <= ssc_q[`SSC_LANE_RESET_BIT];
            // mode output trails the bank register by one clock
            four_byte_address_mode_o <= bank_q[`BANK_EXT_ADDR_BIT];
            boot_read_enable_o       <= boot_q[`BOOT_ENABLE_BIT];
            // (RULE13) aligned start address
            boot_start_address_o     <= boot_q[31:9];
            // (RULE14) start delay
            boot_start_delay_o       <= boot_q[8:1];
            // (RULE16) high bits forced to zero, not taken from the bank
            // (RULE17) host supplies all bits
            // (RULE20) bank bits 1:0 unused
            if (bank_q[`BANK_EXT_ADDR_BIT])
                array_addr_o <= addr4_i;
            else
                array_addr_o <= {8'h00, addr3_i};
        end
    end
endmodule // flash_config_status_regs
`default_nettype wire

// ---- hdl/reg_shift_out.v ----
`timescale 1ns/1ps
`default_nettype none
// loads a word and shifts it out msb first, one bit per enable
module reg_shift_out (
    // clock and reset
    input  wire        clk_i,
    input  wire        rstn_i,
    // control
    input  wire        load_i,
    input  wire [31:0] word_i,
    input  wire        shift_i,
    // serial data
    output reg         bit_o
);
    reg [31:0] sh_q;

    // first bit is presented at load, later bits on each shift
    always @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            sh_q  <= 32'h00000000;
            bit_o <= 1'b0;
        end else if (load_i) begin
            sh_q  <= {word_i[30:0], 1'b0};
            bit_o <= word_i[31];
        end else if (shift_i) begin
            sh_q  <= {sh_q[30:0], 1'b0};
            bit_o <= sh_q[31];
        end
    end
endmodule // reg_shift_out
`default_nettype wire

// ---- sim/fcsr_sva.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "flash_cfg_defs.vh"
// watches configuration outputs against reset sources and link framing
module fcsr_sva (
    // clock and reset
    input wire logic        clk_i,
    input wire logic        rstn_i,
    // inputs
    input wire logic        cs_n_i,
    input wire logic        soft_reset_i,
    input wire logic        hw_reset_i,
    input wire logic [23:0] addr3_i,
    input wire logic [31:0] addr4_i,
    // outputs
    input wire logic        so_oe_o,
    input wire logic [31:0] array_addr_o,
    input wire logic [31:0] erase_size_o,
    input wire logic [8:0]  page_wrap_mask_o,
    input wire logic        lane_three_reset_role_o,
    input wire logic        four_byte_address_mode_o,
    input wire logic        boot_read_enable_o,
    input wire logic        boot_request_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rstn_i);
    property p_bank_map;
        !four_byte_address_mode_o ##1 !four_byte_address_mode_o
            |-> array_addr_o == {8'h00, $past(addr3_i)};
    endproperty
    a_bank_map: assert property (p_bank_map) else $error("bank mode address wrong");
    property p_four_map;
        four_byte_address_mode_o ##1 four_byte_address_mode_o |-> array_addr_o == $past(addr4_i);
    endproperty
    a_four_map: assert property (p_four_map) else $error("four byte address wrong");
    property p_ext_clear;
        (soft_reset_i || hw_reset_i) |-> ##2 !four_byte_address_mode_o;
    endproperty
    a_ext_clear: assert property (p_ext_clear) else $error("extended bit kept");
    property p_boot_go;
        (soft_reset_i || hw_reset_i) && boot_read_enable_o |=> boot_request_o;
    endproperty
    a_boot_go: assert property (p_boot_go) else $error("boot request missing");
    property p_boot_cause;
        boot_request_o |-> $past(soft_reset_i || hw_reset_i);
    endproperty
    a_boot_cause: assert property (p_boot_cause) else $error("boot request uncaused");
    property p_wrap_sticky;
        page_wrap_mask_o == `WRAP_MASK_512 |=> page_wrap_mask_o == `WRAP_MASK_512;
    endproperty
    a_wrap_sticky: assert property (p_wrap_sticky) else $error("wrap bit lost");
    property p_lane_hold;
        !soft_reset_i && !hw_reset_i |=> $stable(lane_three_reset_role_o);
    endproperty
    a_lane_hold: assert property (p_lane_hold) else $error("lane role moved");
    property p_erase_legal;
        erase_size_o == `ERASE_4K || erase_size_o == `ERASE_64K || erase_size_o == `ERASE_256K;
    endproperty
    a_erase_legal: assert property (p_erase_legal) else $error("erase size illegal");
    property p_reply_off;
        $rose(cs_n_i) |-> ##5 !so_oe_o;
    endproperty
    a_reply_off: assert property (p_reply_off) else $error("reply outlives frame");
endmodule // fcsr_sva
bind flash_config_status_regs fcsr_sva i_fcsr_sva (.clk_i(clk_i), .rstn_i(rstn_i),
    .cs_n_i(cs_n_i), .soft_reset_i(soft_reset_i), .hw_reset_i(hw_reset_i), .addr3_i(addr3_i),
    .addr4_i(addr4_i), .so_oe_o(so_oe_o), .array_addr_o(array_addr_o),
    .erase_size_o(erase_size_o), .page_wrap_mask_o(page_wrap_mask_o),
    .lane_three_reset_role_o(lane_three_reset_role_o), .boot_request_o(boot_request_o),
    .four_byte_address_mode_o(four_byte_address_mode_o), .boot_read_enable_o(boot_read_enable_o));
`default_nettype wire

// ---- sim/flash_config_status_regs_tb.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "flash_cfg_defs.vh"
module flash_config_status_regs_tb;
    logic clk, rstn, sck, cs_n, si, so, esus, psus, srst, hrst;
    logic [23:0] addr3;
    logic [31:0] addr4, arr, esz, rd, d, seed;
    logic [8:0] wrap;
    logic [22:0] bsa;
    logic [7:0] bsd;
    logic lane, ext, ben, breq, so_oe, so_line, rw;
    int failures, check_count, cyc, exp_ssc, exp_wr, wr_seen;
    flash_config_status_regs i_flash_config_status_regs (.clk_i(clk), .rstn_i(rstn),
        .sck_i(sck), .cs_n_i(cs_n), .si_i(si), .so_o(so), .so_oe_o(so_oe),
        .erase_suspended_flag_i(esus), .program_suspended_flag_i(psus), .soft_reset_i(srst),
        .hw_reset_i(hrst), .addr3_i(addr3), .addr4_i(addr4), .array_addr_o(arr),
        .erase_size_o(esz), .page_wrap_mask_o(wrap), .lane_three_reset_role_o(lane),
        .four_byte_address_mode_o(ext), .boot_read_enable_o(ben), .boot_start_address_o(bsa),
        .boot_start_delay_o(bsd), .boot_request_o(breq), .reg_write_o(rw));
    spi_host_model i_spi_host_model (.clk_i(clk), .sck_o(sck), .cs_n_o(cs_n), .si_o(si),
        .so_i(so_line));
    // released output reads inverted, so a sample outside the reply window shows up
    assign so_line = so_oe ? so : ~so;
    // count commit pulses between edges, where they stand settled
    always @(negedge clk) begin
        if (rw === 1'b1) wr_seen++;
    end
    // 50 MHz system clock
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    task automatic give_verdict();
        $display("checks %0d failures %0d", check_count, failures);
        if (failures == 0 && check_count > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        check_count++;
        if (got !== exp) begin
            failures++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
        end
    endtask
    // read a register frame and compare with the model value
    task automatic rd_reg(input logic [7:0] cmd, input int n, input logic [31:0] exp);
        i_spi_host_model.xfer(cmd, 32'h00000000, 0, n, rd);
        chk("read reply", exp, rd);
    endtask
    // one-cycle reset source pulse, both kinds capture the lane role
    task automatic pulse(input bit hard);
        {hrst, srst} = {hard, !hard};
        @(negedge clk);
        {hrst, srst} = 2'b00;
        chk("boot request", 32'(d[0]), 32'(breq));
        chk("lane role", 32'(exp_ssc[5]), 32'(lane));
        // mode output and mapped address follow the cleared bank one clock later
        @(negedge clk);
        chk("boot request end", 32'h00000000, 32'(breq));
        chk("ext after reset", 32'h00000000, 32'(ext));
        chk("bank map", {8'h00, addr3}, arr);
    endtask
    // hang guard, well above the few thousand cycles the run needs
    always @(posedge clk) begin
        cyc++;
        if (cyc == 30000) begin
            failures++;
            give_verdict();
        end
    end
    initial begin
        seed = 32'h0000848E;
        {rstn, esus, psus, srst, hrst} = 5'h00;
        addr3 = $random(seed);
        addr4 = $random(seed);
        exp_ssc = 0;
        repeat (4) @(negedge clk);
        rstn = 1'b1;
        repeat (4) @(negedge clk);
        rd_reg(8'h14, 32, `BOOT_RESET);
        rd_reg(8'h16, 8, `BANK_RESET);
        chk("erase size", `ERASE_64K, esz);
        // live suspend flags, every combination
        for (int k = 0; k < 4; k++) begin
            {esus, psus} = 2'(k);
            rd_reg(8'h07, 8, 32'(k));
        end
        {esus, psus} = 2'b00;
        i_spi_host_model.xfer(8'h01, 32'h0000FF, 16, 0, rd);
        rd_reg(8'h07, 8, 32'h00000000);
        // keep hybrid erase, wide wrap and reset role; try writing the flags
        i_spi_host_model.xfer(8'h01, 32'h000063, 24, 0, rd);
        exp_ssc = 'h63 & `SSC_OTP_MASK;
        exp_wr++;
        rd_reg(8'h07, 8, 32'(exp_ssc));
        chk("wrap mask", 32'(`WRAP_MASK_512), 32'(wrap));
        i_spi_host_model.xfer(8'h20, addr4, 24, 0, rd);
        chk("small erase", `ERASE_4K, esz);
        i_spi_host_model.xfer(8'hD8, addr4, 24, 0, rd);
        chk("block erase", `ERASE_64K, esz);
        d = $random(seed) | 32'h00000001;
        i_spi_host_model.xfer(8'h15, d, 32, 0, rd);
        exp_wr++;
        rd_reg(8'h14, 32, d);
        chk("boot fields", {d[31:9], d[8:1], 1'b1}, {bsa, bsd, ben});
        // both bank write codes, reserved bits dropped, then each reset source
        for (int k = 0; k < 2; k++) begin
            i_spi_host_model.xfer(k ? 8'hB9 : 8'h17, 32'h000000FF, 8, 0, rd);
            exp_wr++;
            rd_reg(8'h16, 8, 32'(`BANK_WRITE_MASK));
            chk("four byte map", addr4, arr);
            pulse(k[0]);
        end
        // power cycle mid-run, then pick uniform erase before any erase command
        rstn = 1'b0;
        repeat (4) @(negedge clk);
        rstn = 1'b1;
        repeat (4) @(negedge clk);
        chk("lane after power-on", 32'h00000000, 32'(lane));
        i_spi_host_model.xfer(8'h01, 32'h000080, 24, 0, rd);
        exp_ssc = 'h80 & `SSC_OTP_MASK;
        exp_wr++;
        i_spi_host_model.xfer(8'hD8, addr4, 24, 0, rd);
        chk("uniform erase", `ERASE_256K, esz);
        rd_reg(8'h07, 8, 32'(exp_ssc));
        chk("write pulses", 32'(exp_wr), 32'(wr_seen));
        give_verdict();
    end
endmodule // flash_config_status_regs_tb
`default_nettype wire

// ---- sim/spi_host_model.sv ----
`timescale 1ns/1ps
`default_nettype none
// host controller, mode 0; link clock parked low between frames
module spi_host_model (
    // pacing clock
    input  wire logic clk_i,
    // link pins
    output var  logic sck_o,
    output var  logic cs_n_o,
    output var  logic si_o,
    input  wire logic so_i
);
    // idle link
    initial begin
        sck_o = 1'b0;
        cs_n_o = 1'b1;
        si_o = 1'b0;
    end
    // four system cycles per half gives the 160 ns link clock
    task automatic half();
        repeat (4) @(negedge clk_i);
    endtask
    // command, nw data bits, then nr reply bits; released data line toggles
    task automatic xfer(input logic [7:0] cmd, input logic [31:0] wd, input int nw,
                        input int nr, output logic [31:0] rd);
        logic [39:0] sh;
        sh = {cmd, wd << (32 - nw)};
        rd = 32'h00000000;
        cs_n_o = 1'b0;
        for (int i = 0; i < 8 + nw + nr; i++) begin
            si_o = (i < 8 + nw) ? sh[39 - i] : ~si_o;
            half();
            sck_o = 1'b1;
            if (i >= 8 + nw) rd = {rd[30:0], so_i};
            half();
            sck_o = 1'b0;
        end
        half();
        cs_n_o = 1'b1;
        si_o = ~si_o;
        repeat (8) @(negedge clk_i);
    endtask
endmodule // spi_host_model
`default_nettype wire
